// file: core/jie_pkg.sv
// Shared constants for the jump and increment execution block.
package jie_pkg;
    localparam int         COUNTER_WIDTH = 21;
    localparam int         FILE_AWIDTH  = 12;
    // Jump: first word carries upper bits 1110 1111, second word upper nibble 1111.
    localparam logic [7:0] JUMP_W1_OP   = 8'hef;
    localparam logic [3:0] JUMP_W2_OP   = 4'hf;
    // Increment: bits 15:10 are 0010 10, then destination bit and access bit.
    localparam logic [5:0] INC_OP       = 6'h0a;
    localparam int         INC_DEST_BIT = 9;
    localparam int         INC_ACC_BIT  = 8;
    localparam logic       DEST_W       = 1'h0;
    localparam logic       ACC_ACCESS   = 1'h0;
    // Indexed literal offset applies to file addresses at or below this value.
    localparam logic [7:0] INDEX_LIMIT  = 8'h5f;
    // Access bank: addresses below the split map low, the rest to the top page.
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
    localparam logic [3:0] ACCESS_LOW_PAGE  = 4'h0;
    // Status flag positions.
    localparam int         FLAG_C       = 0;
    localparam int         FLAG_DIGIT_CARRY = 1;
    localparam int         FLAG_Z       = 2;
    localparam int         FLAG_OVERFLOW = 3;
    localparam int         FLAG_N       = 4;
    localparam int         FLAG_COUNT   = 5;
    // Values after reset, and the program counter step.
    localparam logic [20:0] COUNTER_RESET = 21'h000000;
    localparam logic [7:0]  WREG_RESET   = 8'h00;
    localparam logic [4:0]  STATUS_RESET = 5'h00;
    localparam logic [20:0] COUNTER_STEP  = 21'h000002;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} jie_phase_t;
endpackage : jie_pkg

// file: core/jie_inc_alu.sv
// Eight-bit incrementer with carry, digit carry, negative, overflow and zero flags.
`timescale 1ns/1ps
module jie_inc_alu (
    input  wire logic [7:0] i_operand,
    output logic      [7:0] o_sum,
    output logic      [4:0] o_flags
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    assign full_sum = {1'h0, i_operand} + 9'h001;
    assign low_sum  = {1'h0, i_operand[3:0]} + 5'h01;
    assign o_sum    = full_sum[7:0];
    assign o_flags[jie_pkg::FLAG_C]  = full_sum[8];
    assign o_flags[jie_pkg::FLAG_DIGIT_CARRY] = low_sum[4];
    assign o_flags[jie_pkg::FLAG_Z]  = (full_sum[7:0] == 8'h00);
    // Adding one overflows only when a positive operand turns negative.
    assign o_flags[jie_pkg::FLAG_OVERFLOW] = ~i_operand[7] & full_sum[7];
    assign o_flags[jie_pkg::FLAG_N]  = full_sum[7];
endmodule : jie_inc_alu

// file: core/jie_exec.sv
// Four-phase decode and execute of the unconditional jump and the register increment.
`timescale 1ns/1ps
// Operation
// RQ1: The jump loads its 20-bit literal into program counter bits 20 to 1, replacing them.
// RQ2: The jump is taken whatever the flags and reaches anywhere in the 2-Mbyte space.
// RQ3: The jump is two words, 1110 1111 plus literal 7:0, then 1111 plus literal 19:8.
// RQ4: The jump takes two cycles, reading low bits in Q2, high bits and writing the counter in Q4, then a dead cycle.
// RQ5: The increment adds one to the file register and puts it in the accumulator for destination 0, else back in the register.
// RQ6: The increment is decoded from 0010 10 plus destination and access bits and an 8-bit file address.
// RQ7: Access bit 0 uses the access bank and access bit 1 uses the bank select register.
// RQ8: With the extended set on and access bit 0, file addresses up to 95 use indexed literal offset addressing.
// RQ9: The increment updates carry, digit carry, negative, overflow and zero; the jump touches no flag.
// RQ10: The increment finishes in one cycle: decode Q1, read Q2, compute Q3, write Q4.
// RQ11: The jump clears program counter bit 0 so the target is word aligned.
module jie_exec (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_instr_word,
    input  wire logic [15:0] i_next_word,
    input  wire logic        i_ext_set_enable,
    input  wire logic [3:0]  i_bank_select_register,
    input  wire logic [11:0] i_index_base,
    input  wire logic [7:0]  i_rf_rdata,
    output logic      [20:0] o_program_counter,
    output logic      [1:0]  o_phase,
    output logic             o_cycle_end,
    output logic             o_dead_cycle,
    output logic      [11:0] o_rf_addr,
    output logic             o_rf_rd,
    output logic             o_rf_we,
    output logic      [7:0]  o_rf_wdata,
    output logic      [7:0]  o_wreg,
    output logic      [4:0]  o_status
);
    jie_pkg::jie_phase_t phase;
    jie_pkg::jie_phase_t next_phase;

    logic [15:0] instr;
    logic        is_jump;
    logic        is_inc;
    logic        dead;
    logic [7:0]  jump_low;
    logic [7:0]  operand;
    logic [7:0]  result;
    logic [4:0]  result_flags;
    logic [20:0] program_counter;
    logic [11:0] rf_addr;
    logic [7:0]  rf_wdata;
    logic [7:0]  wreg;
    logic [4:0]  status;

    // Decode of the word presented in Q1.
    wire  [7:0]  dec_file    = i_instr_word[7:0];
    wire         dec_acc     = i_instr_word[jie_pkg::INC_ACC_BIT];
    wire         dec_jump    = (i_instr_word[15:8] == jie_pkg::JUMP_W1_OP); // [RQ3]
    wire         dec_inc     = (i_instr_word[15:10] == jie_pkg::INC_OP); // [RQ6]
    wire         dec_indexed = i_ext_set_enable && (dec_acc == jie_pkg::ACC_ACCESS)
                               && (dec_file <= jie_pkg::INDEX_LIMIT); // [RQ8]
    wire  [11:0] addr_indexed = i_index_base + {4'h0, dec_file}; // [RQ8]
    wire  [11:0] addr_banked  = {i_bank_select_register, dec_file}; // [RQ7]
    wire  [11:0] addr_access  = (dec_file < jie_pkg::ACCESS_SPLIT)
                                ? {jie_pkg::ACCESS_LOW_PAGE, dec_file}
                                : {jie_pkg::ACCESS_HIGH_PAGE, dec_file}; // [RQ7]
    wire  [11:0] next_rf_addr = dec_indexed ? addr_indexed
                              : (dec_acc == jie_pkg::ACC_ACCESS) ? addr_access
                              : addr_banked; // [RQ7]
    wire         dest_is_w   = (instr[jie_pkg::INC_DEST_BIT] == jie_pkg::DEST_W);
    // The second jump word is only used when it carries the continuation nibble.
    wire         jump_w2_ok  = (i_next_word[15:12] == jie_pkg::JUMP_W2_OP); // [RQ3]
    // No flag gates the jump; any 20-bit target covers the whole 2-Mbyte space.
    wire  [11:0] jump_high   = i_next_word[11:0]; // [RQ3]
    wire  [20:0] jump_target = {jump_high, jump_low, 1'h0}; // [RQ1] [RQ2] [RQ11]
    wire         exec_jump   = is_jump && !dead && jump_w2_ok; // [RQ2]
    wire         exec_inc    = is_inc && !dead;

    jie_inc_alu u_alu (
        .i_operand (operand),
        .o_sum     (result),
        .o_flags   (result_flags)
    );

    always_comb begin
        unique case (phase)
            jie_pkg::PH_Q1: next_phase = jie_pkg::PH_Q2;
            jie_pkg::PH_Q2: next_phase = jie_pkg::PH_Q3;
            jie_pkg::PH_Q3: next_phase = jie_pkg::PH_Q4;
            jie_pkg::PH_Q4: next_phase = jie_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase <= jie_pkg::PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    // Phase strobes shared by the per-phase registers below.
    wire         in_q1       = (phase == jie_pkg::PH_Q1);
    wire         in_q2       = (phase == jie_pkg::PH_Q2);
    wire         in_q3       = (phase == jie_pkg::PH_Q3);
    wire         in_q4       = (phase == jie_pkg::PH_Q4);
    // Commit strobes gate the arithmetic so a dead cycle or a jump writes nothing.
    wire         capture_sum = in_q3 && exec_inc;
    wire         commit_inc  = in_q4 && exec_inc;

    // Next values; every register below except the Q1 latches only copies its next value.
    wire  [7:0]  next_jump_low = in_q2 ? instr[7:0] : jump_low; // [RQ4]
    // The operand is taken for a jump too; the read strobe stays low, so it is never used.
    wire  [7:0]  next_operand  = in_q2 ? i_rf_rdata : operand; // [RQ10]
    wire  [7:0]  next_rf_wdata = capture_sum ? result : rf_wdata; // [RQ10]
    // Flags follow every increment, whatever its destination.
    wire  [4:0]  next_status   = commit_inc ? result_flags : status; // [RQ9]
    wire  [7:0]  next_wreg     = (commit_inc && dest_is_w) ? rf_wdata : wreg; // [RQ5]
    wire         next_dead     = in_q4 ? exec_jump : dead; // [RQ4]
    // The dead cycle holds the counter so the target word is fetched next.
    wire  [20:0] next_program_counter = !in_q4 ? program_counter
                                      : exec_jump ? jump_target // [RQ1] [RQ4] [RQ11]
                                      : dead ? program_counter
                                      : program_counter + jie_pkg::COUNTER_STEP;

    // Q1: latch the instruction word.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            instr <= 16'h0000;
        end else if (in_q1) begin
            instr <= i_instr_word;
        end
    end

    // Q1: the dead cycle after a jump decodes nothing.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            is_jump <= 1'h0;
            is_inc  <= 1'h0;
        end else if (in_q1) begin
            is_jump <= dec_jump && !dead; // [RQ4]
            is_inc  <= dec_inc && !dead; // [RQ10]
        end
    end

    // Q1: the file address is resolved from the bank inputs of the same cycle.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rf_addr <= 12'h000;
        end else if (in_q1) begin
            rf_addr <= next_rf_addr; // [RQ6] [RQ7] [RQ8]
        end
    end

    // Q2: low literal byte of the jump.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            jump_low <= 8'h00;
        end else begin
            jump_low <= next_jump_low;
        end
    end

    // Q2: the operand is taken while the read strobe stands and held until the next Q2.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            operand <= 8'h00;
        end else begin
            operand <= next_operand;
        end
    end

    // Q3: the sum is held in a flip-flop so the write data never glitches.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rf_wdata <= 8'h00;
        end else begin
            rf_wdata <= next_rf_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            status <= jie_pkg::STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Q4: the accumulator takes the sum only for destination 0.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wreg <= jie_pkg::WREG_RESET;
        end else begin
            wreg <= next_wreg;
        end
    end

    // Q4: the counter steps one word, takes the jump target, or holds in the dead cycle.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            program_counter <= jie_pkg::COUNTER_RESET;
        end else begin
            program_counter <= next_program_counter;
        end
    end

    // Q4: the dead flag covers exactly one instruction cycle after a taken jump.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dead <= 1'h0;
        end else begin
            dead <= next_dead;
        end
    end

    assign o_program_counter = program_counter;
    assign o_phase           = phase;
    assign o_cycle_end       = (phase == jie_pkg::PH_Q4);
    assign o_dead_cycle      = dead;
    assign o_rf_addr         = rf_addr;
    assign o_rf_rd           = (phase == jie_pkg::PH_Q2) && exec_inc; // [RQ10]
    assign o_rf_we           = (phase == jie_pkg::PH_Q4) && exec_inc && !dest_is_w; // [RQ5]
    assign o_rf_wdata        = rf_wdata;
    assign o_wreg            = wreg;
    assign o_status          = status; // [RQ9]
endmodule : jie_exec

// file: sim/jie_exec_monitor.sv
// Concurrent checks on the ports of the jump and increment execution block.
`timescale 1ns/1ps
module jie_exec_monitor (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic [7:0]  i_rf_rdata,
    input wire logic [20:0] o_program_counter,
    input wire logic [1:0]  o_phase,
    input wire logic        o_cycle_end,
    input wire logic        o_dead_cycle,
    input wire logic        o_rf_rd,
    input wire logic        o_rf_we,
    input wire logic [7:0]  o_rf_wdata,
    input wire logic [4:0]  o_status
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_dead_hold;
        (o_dead_cycle && !o_rf_rd && $stable(o_program_counter))[*3];
    endsequence
    sequence s_dead_exit;
        !o_dead_cycle && $stable(o_program_counter);
    endsequence
    a_phase_step: assert property (!$past(i_reset) |-> o_phase == $past(o_phase) + 2'h1)
        else $error("phase did not advance by one");
    a_cycle_end_q4: assert property (o_cycle_end == (o_phase == 2'h3))
        else $error("cycle end outside Q4");
    a_read_in_q2: assert property (o_rf_rd |-> o_phase == 2'h1)
        else $error("register read outside Q2");
    a_write_after_read: assert property (o_rf_we |-> o_phase == 2'h3 && $past(o_rf_rd, 2))
        else $error("register write without read two clocks before");
    a_write_sum: assert property (o_rf_we |-> o_rf_wdata == $past(i_rf_rdata, 2) + 8'h01)
        else $error("written value is not read value plus one");
    a_pc_aligned: assert property (o_program_counter[0] == 1'b0)
        else $error("program counter bit 0 set");
    a_pc_steady: assert property (o_phase != 2'h0 |-> $stable(o_program_counter))
        else $error("program counter moved outside Q4 edge");
    a_dead_cycle: assert property ($rose(o_dead_cycle) |-> o_phase == 2'h0 ##1 s_dead_hold ##1 s_dead_exit)
        else $error("dead cycle not four quiet clocks");
    a_jump_flags: assert property ($rose(o_dead_cycle) |-> $stable(o_status))
        else $error("jump changed status flags");
endmodule : jie_exec_monitor

bind jie_exec jie_exec_monitor i_jie_exec_monitor (.*);

// file: sim/jie_rf_model.sv
// Byte-wide register file that answers the block's read and write strobes.
`timescale 1ns/1ps
module jie_rf_model (
    input  wire logic        i_clk,
    input  wire logic [11:0] i_rf_addr,
    input  wire logic        i_rf_rd,
    input  wire logic        i_rf_we,
    input  wire logic [7:0]  i_rf_wdata,
    output logic      [7:0]  o_rf_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] last = 8'h00;
    // Outside a read the bus shows the inverse of the last data, so stale values cannot pass.
    assign o_rf_rdata = i_rf_rd ? mem[i_rf_addr] : ~last;
    initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
    always @(posedge i_clk) begin
        if (i_rf_we) mem[i_rf_addr] <= i_rf_wdata;
        if (i_rf_rd) last <= mem[i_rf_addr];
    end
endmodule : jie_rf_model

// file: sim/jie_exec_tb_top.sv
// Self-checking bench for the jump and increment execution block.
`timescale 1ns/1ps
module jie_exec_tb_top;
    logic        clk = 0, rst = 1, ext = 0, we, rdn, ce, dead;
    logic [15:0] iw = 16'h0000, nw = 16'h0000;
    logic [3:0]  bank = 4'h0;
    logic [11:0] base = 12'h000, ra, ad;
    logic [7:0]  rd, wd, w, f, v, s, ew = 8'h00, rm [4096];
    logic [20:0] ctr, exp_ctr = 21'h000000;
    logic [4:0]  st, es = 5'h00;
    logic [1:0]  ph;
    logic [31:0] r;
    int          miscompares = 0, cmp_count = 0, seed = 80488, cyc = 0;
    always #10 clk = ~clk;
    jie_exec i_jie_exec (.i_clk(clk), .i_reset(rst), .i_instr_word(iw), .i_next_word(nw),
        .i_ext_set_enable(ext), .i_bank_select_register(bank), .i_index_base(base),
        .i_rf_rdata(rd), .o_program_counter(ctr), .o_phase(ph), .o_cycle_end(ce),
        .o_dead_cycle(dead), .o_rf_addr(ra), .o_rf_rd(rdn), .o_rf_we(we),
        .o_rf_wdata(wd), .o_wreg(w), .o_status(st));
    jie_rf_model i_jie_rf_model (.i_clk(clk), .i_rf_addr(ra), .i_rf_rd(rdn), .i_rf_we(we),
        .i_rf_wdata(wd), .o_rf_rdata(rd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        for (int i = 0; i < 4096; i++) rm[i] = i[7:0];
        repeat (16) @(negedge clk);
        rst = 0;
        for (int n = 0; n < 400; n++) begin
            r = $random(seed);
            {ext, bank, base} = {r[0], r[7:4], r[19:8]};
            nw = {r[22] ? 4'hf : 4'h7, r[11:0]};
            iw = {6'h0a, r[21:20], r[31:24]};
            if (r[3:1] == 3'h0) iw = {8'hef, r[31:24]};
            if (r[3:1] == 3'h1) iw = {4'h0, r[31:20]};
            f = iw[7:0];
            // Reference: access bank splits at 80h, indexed mode below 60h.
            ad = iw[8] ? {bank, f} : (ext && f <= 8'h5f) ? base + 12'(f) : f < 8'h80 ? 12'(f) : {4'hf, f};
            if (iw[15:8] == 8'hef && nw[15:12] == 4'hf) exp_ctr = {nw[11:0], iw[7:0], 1'b0};
            else exp_ctr = exp_ctr + 21'h2;
            if (iw[15:10] == 6'h0a) begin
                v = rm[ad];
                s = v + 8'h01;
                es = {s[7], v == 8'h7f, s == 8'h00, v[3:0] == 4'hf, v == 8'hff};
                if (iw[9]) rm[ad] = s;
                else ew = s;
            end
            repeat (4) @(negedge clk);
            chk(32'(ctr), 32'(exp_ctr), "program counter");
            chk(32'(w), 32'(ew), "accumulator");
            chk(32'(st), 32'(es), "status flags");
            chk(32'(i_jie_rf_model.mem[ad]), 32'(rm[ad]), "register file");
            if (iw[15:8] == 8'hef && nw[15:12] == 4'hf) begin
                iw = r[15:0] ^ r[31:16];
                repeat (4) @(negedge clk);
                chk(32'(ctr), 32'(exp_ctr), "dead cycle");
            end
            if (n == 200) begin
                rst = 1;
                repeat (2) @(negedge clk);
                {rst, exp_ctr, ew, es} = '0;
            end
        end
        print_verdict();
    end
endmodule : jie_exec_tb_top
